/* rtl/drop_receive_port.sv */
// Purpose: drop bus receive port with slot indication and drop-timed add bus
// Assumes: pins come from another clock domain, register port on sys_clk
// Notes: slot numbering counts payload bytes after J1, except V1 bytes, modulo the slot count
//
// Operation
// (RULE1) sender runs byte clock 19.44 or 6.48 MHz
// (RULE2) sample byte and flags on falling edge
// (RULE3) drop clock selectable as add bus timing
// (RULE4) launch add outputs on rising selected slots
// (RULE5) sender gives odd parity over byte, flags
// (RULE6) even-parity bit switches check to even
// (RULE7) data-only bit drops flags from parity
// (RULE8) data bit 7 is first received bit
// (RULE9) payload indicator high payload, low overhead
// (RULE10) timing pulse with payload low marks C1
// (RULE11) timing pulse with payload high marks J1
// (RULE12) further payload pulses are V1 multiframe marks
// (RULE13) slot indication only after enable written one
// (RULE14) slot indication low in selected port slots
// (RULE15) parity mismatch sets sticky error flag
`timescale 1ns/1ps
module drop_receive_port
  import drop_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter logic [SLOT_W-1:0] SLOTS = NUM_SLOTS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic drop_bus_clock,
  input wire logic [7:0] drop_data,
  input wire logic drop_parity_bit,
  input wire logic drop_payload_indicator,
  input wire logic drop_frame_timing_indicator,
  output logic drop_slot_indication_b,
  input wire logic [7:0] add_data,
  output logic add_data_ack,
  output logic [7:0] add_bus_data,
  output logic add_bus_parity,
  output logic add_bus_oe,
  output logic add_indicator_b,
  output logic irq
);

  // ----------------------------------------------------------------
  // sampling and parity
  // ----------------------------------------------------------------
  drop_sample_if smp ();
  logic parity_err;
  logic [7:0] ctrl_r;
  logic [7:0] parity_ctrl_r;
  logic [SLOT_W-1:0] trib_r [PORTS];
  logic [NUM_EVENTS-1:0] status_r;
  logic [NUM_EVENTS-1:0] status_nxt;
  logic [NUM_EVENTS-1:0] mask_r;
  logic [7:0] last_byte_r;
  logic [7:0] rdata_r;
  frame_state_e state_r;
  frame_state_e state_nxt;
  logic [SLOT_W-1:0] slot_r;
  logic [SLOT_W-1:0] slot_nxt;
  logic [1:0] mf_phase_r;
  logic slot_hit_r;
  logic ind_b_r;
  logic irq_r;
  logic [7:0] add_data_r;
  logic add_par_r;
  logic add_oe_r;
  logic add_ind_b_r;
  logic add_ack_r;

  // pins cross into the sys_clk domain here
  drop_pin_sampler u_sampler (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .drop_bus_clock(drop_bus_clock),
    .drop_data(drop_data),
    .drop_parity_bit(drop_parity_bit),
    .drop_payload_indicator(drop_payload_indicator),
    .drop_frame_timing_indicator(drop_frame_timing_indicator),
    .smp(smp.src)
  );

  drop_parity_check u_parity (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .smp(smp.dst),
    .even_parity_select(parity_ctrl_r[PAR_EVEN_BIT]),
    .parity_data_only(parity_ctrl_r[PAR_DATA_ONLY_BIT]),
    .parity_err(parity_err)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
  wire wr_par = reg_wr & (reg_addr == REG_PARITY_CTRL);
  wire wr_status = reg_wr & (reg_addr == REG_STATUS);
  wire wr_mask = reg_wr & (reg_addr == REG_MASK);
  wire [ADDR_W-1:0] trib_idx = reg_addr - REG_TRIB_BASE;
  wire [1:0] trib_pick = trib_idx[1:0];
  wire trib_sel = (reg_addr >= REG_TRIB_BASE) &&
                  (reg_addr < REG_TRIB_BASE + ADDR_W'(PORTS));
  wire [PORTS-1:0] slot_enable = ctrl_r[PORTS-1:0];
  wire add_from_drop = ctrl_r[CTRL_ADD_TIMING_BIT];
  wire wr_trib = reg_wr & trib_sel;
  // irq follows a mask written in this same cycle
  wire [NUM_EVENTS-1:0] mask_nxt = wr_mask ? reg_wdata[NUM_EVENTS-1:0] : mask_r;

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  // (RULE10) pulse in overhead is C1
  wire c1_evt = smp.fall & smp.fti & ~smp.spe;
  // (RULE11) J1 taken only after C1
  wire j1_evt = smp.fall & smp.fti & smp.spe & (state_r == FR_WAIT_J1);
  // (RULE12) later payload pulses are V1
  wire v1_evt = smp.fall & smp.fti & smp.spe & (state_r == FR_LOCKED);
  // (RULE9) only payload bytes advance slots
  wire pay_byte = smp.fall & smp.spe & ~smp.fti & (state_r == FR_LOCKED);

  // hunt for C1, wait for J1, then count slots
  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    case (state_r)
      FR_HUNT: begin
        if (c1_evt) begin
          state_nxt = FR_WAIT_J1;
        end
      end
      FR_WAIT_J1: begin
        if (j1_evt) begin
          state_nxt = FR_LOCKED;
          slot_nxt = '0;
        end
      end
      FR_LOCKED: begin
        if (c1_evt) begin
          state_nxt = FR_WAIT_J1;
        end else if (pay_byte) begin
          slot_nxt = (slot_r == SLOTS - SLOT_W'(1)) ? '0 : slot_r + SLOT_W'(1);
        end
      end
      default: begin
        state_nxt = FR_HUNT;
      end
    endcase
  end

  // (RULE14) slot matches an enabled port
  logic [PORTS-1:0] port_hit;
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      port_hit[p] = slot_enable[p] && (trib_r[p] == slot_nxt);
    end
  end
  // slot of the byte being sampled now
  wire hit_now = (state_nxt == FR_LOCKED) & smp.spe & (|port_hit);

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  wire [NUM_EVENTS-1:0] events = {v1_evt, j1_evt, c1_evt, parity_err};
  // (RULE15) sticky, set wins over clear
  // a clear never hides an event of the same cycle
  always_comb begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_r & ~reg_wdata[NUM_EVENTS-1:0];
    end
    status_nxt = status_nxt | events;
  end

  wire [7:0] state_view = {4'h0, mf_phase_r, state_r};
  // unmapped addresses read as zero
  wire [7:0] trib_view = trib_sel ? {2'b00, trib_r[trib_pick]} : 8'h00;
  wire [7:0] rd_mux =
    (reg_addr == REG_CTRL) ? ctrl_r :
    (reg_addr == REG_PARITY_CTRL) ? parity_ctrl_r :
    (reg_addr == REG_STATUS) ? {4'h0, status_r} :
    (reg_addr == REG_MASK) ? {4'h0, mask_r} :
    (reg_addr == REG_STATE) ? state_view :
    (reg_addr == REG_LAST_BYTE) ? last_byte_r :
    trib_view;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
      parity_ctrl_r <= PARITY_CTRL_RST;
      mask_r <= MASK_RST[NUM_EVENTS-1:0];
      status_r <= '0;
      rdata_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata;
      end
      // (RULE6) (RULE7) parity options held here
      if (wr_par) begin
        parity_ctrl_r <= {6'h00, reg_wdata[1:0]};
      end
      if (wr_mask) begin
        mask_r <= reg_wdata[NUM_EVENTS-1:0];
      end
      status_r <= status_nxt;
      // read data stand for one cycle only
      rdata_r <= reg_rd ? rd_mux : 8'h00;
      // level irq from the updated status and mask
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int p = 0; p < PORTS; p++) begin
        trib_r[p] <= TRIB_RST[SLOT_W-1:0];
      end
    end else if (wr_trib) begin
      trib_r[trib_pick] <= reg_wdata[SLOT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_r <= FR_HUNT;
      slot_r <= '0;
      mf_phase_r <= '0;
      last_byte_r <= '0;
      slot_hit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      // (RULE12) V1 restarts multiframe
      // phase counts J1 bytes since the last V1
      if (v1_evt) begin
        mf_phase_r <= '0;
      end else if (j1_evt) begin
        mf_phase_r <= mf_phase_r + 2'b01;
      end
      if (smp.fall) begin
        last_byte_r <= smp.data;
        // steers the launch at the next rising edge
        slot_hit_r <= hit_now;
      end
    end
  end

  // ----------------------------------------------------------------
  // slot indication and add bus launch
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ind_b_r <= 1'b1;
      add_data_r <= '0;
      add_par_r <= 1'b0;
      add_oe_r <= 1'b0;
      add_ind_b_r <= 1'b1;
      add_ack_r <= 1'b0;
    end else begin
      add_ack_r <= 1'b0;
      // (RULE13) (RULE14) low in selected slots
      if (smp.fall) begin
        ind_b_r <= ~hit_now;
      end
      // (RULE3) (RULE4) launch at rising edge
      if (smp.rise) begin
        if (add_from_drop && slot_hit_r) begin
          add_data_r <= add_data;
          add_par_r <= expected_parity(add_data, 1'b0, 1'b0, 1'b0, 1'b1);
          add_oe_r <= 1'b1;
          add_ind_b_r <= 1'b0;
          add_ack_r <= 1'b1;
        end else begin
          // released outside the selected slots
          add_oe_r <= 1'b0;
          add_ind_b_r <= 1'b1;
        end
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign drop_slot_indication_b = ind_b_r;
  assign add_data_ack = add_ack_r;
  assign add_bus_data = add_data_r;
  assign add_bus_parity = add_par_r;
  assign add_bus_oe = add_oe_r;
  assign add_indicator_b = add_ind_b_r;
  assign irq = irq_r;

endmodule : drop_receive_port

/* rtl/drop_pkg.sv */
// Purpose: shared constants, types and functions of the drop bus receive port
// Assumes: 8-bit register port, byte addressed
// Notes: parity helper is used by the checker and by the add bus launch
package drop_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TRIB_BASE = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h09;
  localparam logic [7:0] REG_STATE = 8'h0a;
  localparam logic [7:0] REG_LAST_BYTE = 8'h0b;
  localparam logic [7:0] REG_PARITY_CTRL = 8'h12;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int PAR_EVEN_BIT = 0;
  localparam int PAR_DATA_ONLY_BIT = 1;
  localparam int CTRL_ADD_TIMING_BIT = 4;
  localparam int ST_PAR_ERR = 0;
  localparam int ST_C1 = 1;
  localparam int ST_J1 = 2;
  localparam int ST_V1 = 3;
  localparam int NUM_EVENTS = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PARITY_CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] TRIB_RST = 8'h00;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int SLOT_W = 6;
  localparam logic [SLOT_W-1:0] NUM_SLOTS = 6'h3f;
  localparam int SYNC_STAGES = 2;
  localparam int PIN_W = 12;

  typedef enum logic [1:0] {
    FR_HUNT = 2'b00,
    FR_WAIT_J1 = 2'b01,
    FR_LOCKED = 2'b11
  } frame_state_e;

  // parity bit that a correct sender would put beside this byte
  function automatic logic expected_parity(input logic [7:0] data, input logic spe,
                                           input logic fti, input logic even,
                                           input logic data_only);
    logic ones;
    ones = ^data;
    if (!data_only) begin
      ones = ones ^ spe ^ fti;
    end
    expected_parity = even ? ones : ~ones;
  endfunction : expected_parity

endpackage : drop_pkg

/* rtl/drop_sample_if.sv */
// Purpose: carries one sampled drop bus byte and the link clock edges
// Assumes: all signals on sys_clk
// Notes: fall marks a new sampled byte, rise marks a launch point
`timescale 1ns/1ps
interface drop_sample_if;
  logic [7:0] data;
  logic par;
  logic spe;
  logic fti;
  logic fall;
  logic rise;
  modport src (output data, output par, output spe, output fti, output fall, output rise);
  modport dst (input data, input par, input spe, input fti, input fall, input rise);
endinterface : drop_sample_if

/* rtl/drop_pin_sampler.sv */
// Purpose: synchronises drop bus pins and samples them at link clock falls
// Assumes: link clock well below half of sys_clk
// Notes: data pass the same two stages as the clock, so they stay aligned
`timescale 1ns/1ps
module drop_pin_sampler
  import drop_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic drop_bus_clock,
  input wire logic [7:0] drop_data,
  input wire logic drop_parity_bit,
  input wire logic drop_payload_indicator,
  input wire logic drop_frame_timing_indicator,
  drop_sample_if.src smp
);

  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] sync_r;
  logic clk_prev_r;
  logic [PIN_W-2:0] held_r;
  logic fall_r;
  logic rise_r;
  wire [PIN_W-1:0] pins = {drop_bus_clock, drop_data, drop_parity_bit,
                           drop_payload_indicator, drop_frame_timing_indicator};
  wire clk_s = sync_r[PIN_W-1];
  wire fall_det = clk_prev_r & ~clk_s;
  wire rise_det = ~clk_prev_r & clk_s;

  // ----------------------------------------------------------------
  // two-stage synchroniser and edge sampling
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
      clk_prev_r <= 1'b0;
      held_r <= '0;
      fall_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      clk_prev_r <= clk_s;
      // (RULE2) byte taken at falling edge
      if (fall_det) begin
        held_r <= sync_r[PIN_W-2:0];
      end
      fall_r <= fall_det;
      rise_r <= rise_det;
    end
  end

  // (RULE8) bit 7 kept first
  assign smp.data = held_r[10:3];
  assign smp.par = held_r[2];
  assign smp.spe = held_r[1];
  assign smp.fti = held_r[0];
  assign smp.fall = fall_r;
  assign smp.rise = rise_r;

endmodule : drop_pin_sampler

/* rtl/drop_parity_check.sv */
// Purpose: checks the parity of each sampled drop bus byte
// Assumes: fall strobe marks a fresh byte on the interface
// Notes: error is a one-cycle pulse
`timescale 1ns/1ps
module drop_parity_check
  import drop_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  drop_sample_if.dst smp,
  input wire logic even_parity_select,
  input wire logic parity_data_only,
  output logic parity_err
);

  logic err_r;
  // (RULE6) (RULE7) even and data-only options
  wire want = expected_parity(smp.data, smp.spe, smp.fti, even_parity_select,
                              parity_data_only);
  wire mismatch = smp.fall & (want != smp.par);

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      err_r <= 1'b0;
    end else begin
      // (RULE15) flag any mismatch
      err_r <= mismatch;
    end
  end

  assign parity_err = err_r;

endmodule : drop_parity_check

/* verif/drop_bus_source.sv */
// Purpose: drop bus source model, framed bytes on a free byte clock
// Assumes: byte clock period 160 ns, frame of FRAME_LEN bytes
// Notes: corrupt inverts the parity of each byte sent while it is high
`timescale 1ns/1ps
module drop_bus_source #(
  parameter int FRAME_LEN = 90,
  parameter int J1_POS = 9
) (
  input wire logic even,
  input wire logic data_only,
  input wire logic corrupt,
  input wire logic [7:0] fill,
  output logic link_clk,
  output logic [7:0] data,
  output logic par,
  output logic spe,
  output logic fti
);
  int pos;
  initial begin
    pos = FRAME_LEN - 1;
    data = 8'h00;
    par = 1'b1;
    spe = 1'b0;
    fti = 1'b0;
    link_clk = 1'b1;
    forever begin
      #80 link_clk = ~link_clk;
    end
  end
  // ----------------------------------------------------------------
  // byte launch on rising edge
  // ----------------------------------------------------------------
  always @(posedge link_clk) begin
    pos = (pos + 1) % FRAME_LEN;
    spe = pos >= J1_POS;
    fti = pos == 0 || pos == J1_POS || pos == J1_POS + 40;
    data = fill != 8'h00 ? fill : 8'(pos * 37 + 91);
    par = ^data ^ (data_only ? 1'b0 : spe ^ fti) ^ !even ^ corrupt;
  end
endmodule : drop_bus_source

/* verif/drop_receive_port_sva.sv */
// Purpose: port-level checks of the drop bus receive port
// Assumes: register writes seen on the port mirror the control state
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module drop_receive_port_sva
  import drop_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter logic [SLOT_W-1:0] SLOTS = NUM_SLOTS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic drop_bus_clock,
  input wire logic drop_slot_indication_b,
  input wire logic [7:0] add_data,
  input wire logic add_data_ack,
  input wire logic [7:0] add_bus_data,
  input wire logic add_bus_parity,
  input wire logic add_bus_oe,
  input wire logic add_indicator_b,
  input wire logic irq
);
  logic [7:0] ctrl_r;
  logic [7:0] mask_r;
  logic [7:0] par_r;
  logic en_seen_r;
  wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
  // ----------------------------------------------------------------
  // mirror of written control state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
      par_r <= PARITY_CTRL_RST;
      en_seen_r <= 1'b0;
    end else begin
      ctrl_r <= wr_ctrl ? reg_wdata : ctrl_r;
      mask_r <= (reg_wr && reg_addr == REG_MASK) ? reg_wdata : mask_r;
      par_r <= (reg_wr && reg_addr == REG_PARITY_CTRL) ? reg_wdata : par_r;
      en_seen_r <= en_seen_r || (wr_ctrl && reg_wdata[3:0] != 4'h0);
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  AST_PAR_READBACK: assert property (
    $past(reg_rd) && $past(reg_addr) == REG_PARITY_CTRL
    |-> (reg_rdata & 8'h03) == ($past(par_r) & 8'h03)) else $error("parity control readback");
  AST_IRQ_MASKED: assert property (
    mask_r == 8'h00 && $past(mask_r) == 8'h00 |-> !irq) else $error("irq while all masked");
  AST_IND_ENABLE: assert property (
    !en_seen_r |-> drop_slot_indication_b) else $error("indication before enable");
  AST_IND_AT_FALL: assert property (
    $changed(drop_slot_indication_b) |-> !drop_bus_clock) else $error("indication off byte");
  AST_ACK_PULSE: assert property (
    add_data_ack |=> !add_data_ack) else $error("ack longer than one cycle");
  AST_ACK_LAUNCH: assert property (
    add_data_ack |-> drop_bus_clock && add_bus_oe && !add_indicator_b
    && add_bus_data == $past(add_data)) else $error("add launch wrong");
  AST_ADD_PARITY: assert property (
    add_bus_oe |-> add_bus_parity == ~^add_bus_data) else $error("add parity wrong");
  AST_OE_TIMING: assert property (
    $rose(add_bus_oe) |-> ctrl_r[CTRL_ADD_TIMING_BIT]) else $error("add bus without timing");
  AST_ADD_ON_RISE: assert property (
    $changed(add_bus_data) |-> drop_bus_clock) else $error("add data off rising half");
endmodule : drop_receive_port_sva

bind drop_receive_port drop_receive_port_sva #(.PORTS(PORTS), .SLOTS(SLOTS)) u_sva (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drop_bus_clock(drop_bus_clock),
  .drop_slot_indication_b(drop_slot_indication_b), .add_data(add_data),
  .add_data_ack(add_data_ack), .add_bus_data(add_bus_data), .add_bus_parity(add_bus_parity),
  .add_bus_oe(add_bus_oe), .add_indicator_b(add_indicator_b), .irq(irq));

/* verif/drop_receive_port_tb.sv */
// Purpose: self-checking bench of the drop bus receive port
// Assumes: 5 ns system clock, 160 ns byte clock from the source model
// Notes: slot selects of ports 0 to 2 and add bytes are random from seed 47, port 3 selects slot 3e
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module drop_receive_port_tb;
  import drop_pkg::*;
  logic sys_clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic link_clk;
  logic [7:0] drop_data;
  logic dpar;
  logic dspe;
  logic dfti;
  logic ind_b;
  logic [7:0] add_data;
  logic ack;
  logic [7:0] abus;
  logic apar;
  logic aoe;
  logic aind_b;
  logic irq;
  logic even;
  logic donly;
  logic corrupt;
  logic [7:0] fill;
  int error_cnt;
  int num_checks;
  int low_cnt;
  int ack_cnt;
  int oe_cnt;
  int base;
  drop_bus_source src (.even(even), .data_only(donly), .corrupt(corrupt), .fill(fill),
    .link_clk(link_clk), .data(drop_data), .par(dpar), .spe(dspe), .fti(dfti));
  drop_receive_port dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drop_bus_clock(link_clk), .drop_data(drop_data), .drop_parity_bit(dpar),
    .drop_payload_indicator(dspe), .drop_frame_timing_indicator(dfti),
    .drop_slot_indication_b(ind_b), .add_data(add_data), .add_data_ack(ack),
    .add_bus_data(abus), .add_bus_parity(apar), .add_bus_oe(aoe),
    .add_indicator_b(aind_b), .irq(irq));
  initial begin
    sys_clk = 1'b0;
    forever begin
      #2.5 sys_clk = ~sys_clk;
    end
  end
  always @(posedge sys_clk) begin
    low_cnt += (ind_b === 1'b0);
    ack_cnt += (ack === 1'b1);
    oe_cnt += (aoe === 1'b1);
    add_data <= 8'($urandom);
  end
  function automatic logic [7:0] par_ctrl(logic ev, logic dn);
    return (8'(ev) << PAR_EVEN_BIT) | (8'(dn) << PAR_DATA_ONLY_BIT);
  endfunction : par_ctrl
  function automatic logic [7:0] ctrl_val(int port, logic add_t);
    return 8'(1 << port) | (8'(add_t) << CTRL_ADD_TIMING_BIT);
  endfunction : ctrl_val
  task automatic wait_bytes(int n);
    repeat (n * 32) @(posedge sys_clk);
  endtask : wait_bytes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    `CHK(nm, e, reg_rdata & m)
  endtask : rdchk
  task automatic bad_byte;
    corrupt <= 1'b1;
    wait_bytes(1);
    corrupt <= 1'b0;
    wait_bytes(4);
  endtask : bad_byte
  task automatic finish_test;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(47));
    {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {even, donly, corrupt, fill, error_cnt, num_checks} = '0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rdchk("par_rst", REG_PARITY_CTRL, 8'h03, PARITY_CTRL_RST);
    rdchk("ctrl_rst", REG_CTRL, 8'hff, CTRL_RST);
    wr(8'h30, 8'hff);
    rdchk("unmapped", 8'h30, 8'hff, 8'h00);
    for (int m = 0; m < 4; m++) begin
      even <= m[0];
      donly <= m[1];
      wr(REG_PARITY_CTRL, par_ctrl(m[0], m[1]));
      rdchk("par_rb", REG_PARITY_CTRL, 8'h03, par_ctrl(m[0], m[1]));
      wait_bytes(3);
      wr(REG_STATUS, 8'hff);
      wait_bytes(30);
      rdchk("par_ok", REG_STATUS, 8'h01, 8'h00);
      bad_byte();
      rdchk("par_err", REG_STATUS, 8'h01, 8'h01);
      rdchk("par_sticky", REG_STATUS, 8'h01, 8'h01);
    end
    wr(REG_MASK, 8'h01);
    wr(REG_STATUS, 8'hff);
    bad_byte();
    `CHK("irq_set", 1'b1, irq)
    wr(REG_STATUS, 8'h01);
    repeat (3) @(posedge sys_clk);
    `CHK("irq_clr", 1'b0, irq)
    wr(REG_MASK, 8'h00);
    bad_byte();
    `CHK("irq_masked", 1'b0, irq)
    wr(REG_STATUS, 8'hff);
    wait_bytes(100);
    rdchk("frame_marks", REG_STATUS, 8'h0e, 8'h0e);
    wait (src.pos == 30);
    @(posedge sys_clk);
    rdchk("locked", REG_STATE, 8'h03, 8'h03);
    rdchk("mf_phase", REG_STATE, 8'h0c, 8'h04);
    fill <= 8'hb4;
    wait_bytes(4);
    rdchk("last_byte", REG_LAST_BYTE, 8'hff, 8'hb4);
    fill <= 8'h00;
    for (int p = 0; p < 4; p++) begin
      wr(REG_TRIB_BASE + 8'(p), p == 3 ? 8'h3e : 8'($urandom_range(61, 0)));
      wr(REG_CTRL, ctrl_val(p, 1'b0));
      base = low_cnt;
      wait_bytes(100);
      `CHK("ind_low", 1'b1, low_cnt > base)
    end
    `CHK("oe_idle", 0, oe_cnt)
    wr(REG_CTRL, 8'h00);
    wait_bytes(2);
    base = low_cnt;
    wait_bytes(100);
    `CHK("ind_off", base, low_cnt)
    wr(REG_CTRL, ctrl_val(0, 1'b1));
    wait_bytes(100);
    `CHK("add_launch", 1'b1, ack_cnt > 0)
    finish_test();
  end
endmodule : drop_receive_port_tb
